// ---- mps_pkg.sv ----
// package for the multiphase pwm sequencer: constants and carrier types
package mps_pkg;
    localparam int MAX_CHANNELS = 4;
    localparam int PERIOD_W = 16;
    // default interval length in clk cycles (freq select resistor gives the rate)
    localparam logic [PERIOD_W-1:0] DEFAULT_PERIOD = 16'h0064;
    // cycles after reset release before straps are caught
    localparam logic [3:0] STRAP_SETTLE = 4'h4;
    localparam logic [2:0] CHAN_RESET = 3'h4;

    // analog-facing comparator results: per channel crossings plus one shared droop trip
    typedef struct packed {
        logic [MAX_CHANNELS-1:0] crossAbove; // corrected error above ramp
        logic droopTrip;                     // fast droop beyond trip level
    } mps_analog_t;

    typedef enum logic [1:0] {
        MPS_SETTLE,
        MPS_RUN
    } mps_mode_t;

    typedef struct packed {
        mps_mode_t mode;
        logic [3:0] settleCnt;
        logic [2:0] activeChans;
        logic [PERIOD_W-1:0] phaseCnt;
        logic [MAX_CHANNELS-1:0] rosePending;  // rise already used this interval
        logic [MAX_CHANNELS-1:0] pwm;
        logic [MAX_CHANNELS-1:0] intervalStart;
        logic [MAX_CHANNELS-1:0] pulseEnd;
        logic droopAllOn;
        logic nbPwm;
        logic nbRose;
        logic [1:0] stA;
        logic [1:0] stB;
        logic [2:0] strapA;
        logic [2:0] strapB;
    } mps_state_t;
endpackage

// ---- mps_sequencer.sv ----
// multiphase pwm sequencer: interval clock, interleave, pulse position, droop all-on
// Function
// - active channel intervals are evenly spread, offset by period over channel count.
// - with three channels each fires a third of a period after the one before.
// - a channel's cycle runs from one pulse end to its next pulse end.
// - an interval clock of one switching period bounds where a pulse may occur.
// - pwm may rise anywhere in its interval and fall any time after rising.
// - comparison of corrected error against ramp starts at each interval start.
// - pwm is held low while the corrected error is below the ramp.
// - pwm goes high on the crossing and stays high until the next crossing.
// - low pwm means low-side on, high pwm means high-side on, in the gate driver.
// - pwm rises at most once per interval.
// - a fast droop trip forces all active channels high together.
// - channels fire in ascending order one to four, one to three or one to two.
// - strap pins choose four, three, two or one active channel.
// - channel offsets follow the detected channel count.
// - an independent single-phase northbridge pwm is provided.
module mps_sequencer
    import mps_pkg::*;
#(
    parameter logic [PERIOD_W-1:0] PERIOD_CYCLES = DEFAULT_PERIOD
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic chan2_detect_pin,
    input wire logic chan3_detect_pin,
    input wire logic chan4_detect_pin,
    input wire mps_analog_t coreCmp,
    input wire logic nbCrossAbove,
    output logic [MAX_CHANNELS-1:0] corePwm,
    output logic [MAX_CHANNELS-1:0] chanActive,
    output logic [MAX_CHANNELS-1:0] cycleEnd,
    output logic fast_droop_all_on,
    output logic nbPwm
);
    mps_state_t s_q;
    mps_state_t s_d;

    // offset of channel idx for n active channels
    function automatic logic [PERIOD_W-1:0] chanOffset(input logic [2:0] n,
                                                       input int idx);
        logic [PERIOD_W+1:0] prod;
        prod = 18'(PERIOD_CYCLES) * 18'(idx);
        case (n)
            3'h2: chanOffset = PERIOD_W'(prod / 18'h2);
            3'h3: chanOffset = PERIOD_W'(prod / 18'h3);
            3'h4: chanOffset = PERIOD_W'(prod / 18'h4);
            default: chanOffset = '0;
        endcase
    endfunction

    // strap decode into channel count
    function automatic logic [2:0] strapCount(input logic [2:0] p);
        if (p[2] && p[1] && p[0]) begin
            strapCount = 3'h1;
        end else if (p[2] && p[1]) begin
            strapCount = 3'h2;
        end else if (p[2]) begin
            strapCount = 3'h3;
        end else begin
            strapCount = 3'h4;
        end
    endfunction

    // next state
    always_comb begin
        s_d = s_q;
        s_d.strapA = {chan4_detect_pin, chan3_detect_pin, chan2_detect_pin};
        s_d.strapB = s_q.strapA;
        s_d.stA = {coreCmp.droopTrip, nbCrossAbove};
        s_d.stB = s_q.stA;
        s_d.intervalStart = '0;
        s_d.pulseEnd = '0;
        // interval clock free runs once per switching period
        if (s_q.phaseCnt == PERIOD_CYCLES - 1'b1) begin
            s_d.phaseCnt = '0;
        end else begin
            s_d.phaseCnt = s_q.phaseCnt + 1'b1;
        end
        case (s_q.mode)
            MPS_SETTLE: begin
                s_d.settleCnt = s_q.settleCnt + 1'b1;
                s_d.pwm = '0;
                s_d.droopAllOn = 1'b0;
                if (s_q.settleCnt == STRAP_SETTLE) begin
                    s_d.activeChans = strapCount(s_q.strapB);
                    s_d.mode = MPS_RUN;
                end
            end
            MPS_RUN: begin
                s_d.droopAllOn = s_q.stB[1];
                for (int i = 0; i < MAX_CHANNELS; i++) begin
                    if (3'(i) < s_q.activeChans) begin
                        // ascending order, evenly spaced starts
                        if (s_q.phaseCnt == chanOffset(s_q.activeChans, i)) begin
                            s_d.intervalStart[i] = 1'b1;
                            s_d.rosePending[i] = 1'b0;
                        end
                        if (s_q.stB[1]) begin
                            s_d.pwm[i] = 1'b1;
                        end else if (!s_q.pwm[i]) begin
                            // rise on crossing, once per interval
                            if (coreCmp.crossAbove[i] && !s_d.rosePending[i]) begin
                                s_d.pwm[i] = 1'b1;
                                s_d.rosePending[i] = 1'b1;
                            end
                        end else if (!coreCmp.crossAbove[i]) begin
                            // next crossing ends the pulse
                            s_d.pwm[i] = 1'b0;
                            s_d.pulseEnd[i] = 1'b1;
                        end
                    end else begin
                        s_d.pwm[i] = 1'b0;
                        s_d.rosePending[i] = 1'b0;
                    end
                end
                // northbridge single phase on its own interval at offset zero
                if (s_q.phaseCnt == '0) begin
                    s_d.nbRose = 1'b0;
                end
                if (!s_q.nbPwm && s_q.stB[0] && !(s_q.nbRose && s_q.phaseCnt != '0)) begin
                    s_d.nbPwm = 1'b1;
                    s_d.nbRose = 1'b1;
                end else if (s_q.nbPwm && !s_q.stB[0]) begin
                    s_d.nbPwm = 1'b0;
                end
            end
            default: s_d.mode = MPS_SETTLE;
        endcase
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.mode <= MPS_SETTLE;
            s_q.activeChans <= CHAN_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops; driver maps high to high-side on
    assign corePwm = s_q.pwm;
    assign cycleEnd = s_q.pulseEnd;
    assign fast_droop_all_on = s_q.droopAllOn;
    assign nbPwm = s_q.nbPwm;
    logic [MAX_CHANNELS-1:0] actMask_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            actMask_q <= '0;
        end else begin
            for (int i = 0; i < MAX_CHANNELS; i++) begin
                actMask_q[i] <= (s_q.mode == MPS_RUN) && (3'(i) < s_q.activeChans);
            end
        end
    end
    assign chanActive = actMask_q;

    // checks: each property watches the registered state, the top outputs or the comparator inputs
    // reset aborts every property, so a mid-run reset never reports stale history

    // a rise outside the interval start must find the used-rise flag set
    chk_single_rise_interval: assert property (@(posedge clk) disable iff (rst)
        (s_q.mode == MPS_RUN && !s_q.stB[1] && $rose(s_q.pwm[0]) && !s_q.intervalStart[0])
        |-> s_q.rosePending[0])
        else $error("channel rose twice in one interval");

    // a held droop trip keeps every active channel high
    chk_droop_all_high: assert property (@(posedge clk) disable iff (rst)
        (s_q.mode == MPS_RUN && s_q.stB[1]) |=> ((s_q.pwm & actMask_q) == actMask_q || !$past(s_q.stB[1]) || s_q.mode != MPS_RUN))
        else $error("droop trip did not force active channels high");

    // channels outside the strapped count never switch
    chk_inactive_low: assert property (@(posedge clk) disable iff (rst)
        (corePwm & ~chanActive) == '0 || $changed(chanActive))
        else $error("inactive channel driven");

    // strap changes after start are ignored
    chk_strap_fixed: assert property (@(posedge clk) disable iff (rst)
        (s_q.mode == MPS_RUN && $past(s_q.mode) == MPS_RUN) |-> $stable(s_q.activeChans))
        else $error("channel count changed after start");

    // below the ramp a low channel stays low
    chk_low_below_ramp: assert property (@(posedge clk) disable iff (rst)
        (s_q.mode == MPS_RUN && !s_q.pwm[0] && !coreCmp.crossAbove[0] && !s_q.stB[1])
        |=> !s_q.pwm[0])
        else $error("pwm rose while below ramp");

    // the return crossing ends the pulse and flags the cycle end
    chk_fall_on_cross: assert property (@(posedge clk) disable iff (rst)
        (s_q.mode == MPS_RUN && s_q.pwm[0] && !coreCmp.crossAbove[0] && !s_q.stB[1]
         && chanActive[0]) |=> (!s_q.pwm[0] && cycleEnd[0]))
        else $error("pwm did not fall on crossing");

    // interval counter steps by one after wrapping
    chk_interval_period: assert property (@(posedge clk) disable iff (rst)
        (s_q.phaseCnt == '0) |=> (s_q.phaseCnt == PERIOD_W'(1) || PERIOD_CYCLES == 1))
        else $error("interval counter skipped");

    // four channels: the second interval opens a quarter period in
    chk_order_offsets: assert property (@(posedge clk) disable iff (rst)
        (s_q.mode == MPS_RUN && s_q.activeChans == 3'h4 && s_q.phaseCnt == PERIOD_CYCLES / 4)
        |=> s_q.intervalStart[1])
        else $error("channel two start misplaced");

    // northbridge rise is recorded against its interval
    chk_nb_once: assert property (@(posedge clk) disable iff (rst)
        $rose(s_q.nbPwm) |-> (s_q.nbRose))
        else $error("northbridge rise not recorded");

    // a rise not caused by droop needs the comparator above the ramp
    chk_rise_needs_cross: assert property (@(posedge clk) disable iff (rst)
        ($rose(s_q.pwm[0]) && !$past(s_q.stB[1]))
        |-> $past(coreCmp.crossAbove[0]))
        else $error("pwm rose without a crossing");

    // all-on flag follows the synchronised trip one edge later
    chk_droop_flag_follow: assert property (@(posedge clk) disable iff (rst)
        (s_q.mode == MPS_RUN)
        |=> (fast_droop_all_on == $past(s_q.stB[1])))
        else $error("droop flag out of step");

    // interval counter never reaches the period length
    chk_phase_bound: assert property (@(posedge clk) disable iff (rst)
        s_q.phaseCnt < PERIOD_CYCLES)
        else $error("interval counter out of range");

    // channel one opens its interval at count zero
    chk_start_chan_one: assert property (@(posedge clk) disable iff (rst)
        (s_q.mode == MPS_RUN && s_q.phaseCnt == '0)
        |=> s_q.intervalStart[0])
        else $error("channel one start misplaced");

    // two channels: second interval opens half a period in
    chk_two_phase_half: assert property (@(posedge clk) disable iff (rst)
        (s_q.mode == MPS_RUN && s_q.activeChans == 3'h2 && s_q.phaseCnt == PERIOD_CYCLES / 2)
        |=> s_q.intervalStart[1])
        else $error("two channel offset misplaced");

    // three channels: second interval opens a third of a period in
    chk_three_phase_third: assert property (@(posedge clk) disable iff (rst)
        (s_q.mode == MPS_RUN && s_q.activeChans == 3'h3 && s_q.phaseCnt == PERIOD_CYCLES / 3)
        |=> s_q.intervalStart[1])
        else $error("three channel offset misplaced");

    // three channels: third interval follows at two thirds
    chk_three_phase_last: assert property (@(posedge clk) disable iff (rst)
        (s_q.mode == MPS_RUN && s_q.activeChans == 3'h3
         && s_q.phaseCnt == 2 * PERIOD_CYCLES / 3)
        |=> s_q.intervalStart[2])
        else $error("three channel order broken");

    // four channels: last interval opens at three quarters
    chk_four_phase_last: assert property (@(posedge clk) disable iff (rst)
        (s_q.mode == MPS_RUN && s_q.activeChans == 3'h4
         && s_q.phaseCnt == 3 * PERIOD_CYCLES / 4)
        |=> s_q.intervalStart[3])
        else $error("four channel order broken");

    // cycle end marker lasts a single clock
    chk_end_one_cycle: assert property (@(posedge clk) disable iff (rst)
        cycleEnd[0] |=> !cycleEnd[0])
        else $error("cycle end held too long");

    // cycle end only marks a terminated pulse
    chk_end_after_fall: assert property (@(posedge clk) disable iff (rst)
        cycleEnd[0] |-> !corePwm[0])
        else $error("cycle end while pulse high");

    // northbridge pulse ends when its comparator drops
    chk_nb_fall: assert property (@(posedge clk) disable iff (rst)
        (s_q.mode == MPS_RUN && s_q.nbPwm && !s_q.stB[0])
        |=> !s_q.nbPwm)
        else $error("northbridge pulse did not end");

    // nothing switches while straps settle
    chk_settle_quiet: assert property (@(posedge clk) disable iff (rst)
        (s_q.mode == MPS_SETTLE) |-> (s_q.pwm == '0 && !s_q.nbPwm))
        else $error("output switched before straps caught");

    // decoded channel count is always one to four
    chk_active_count_legal: assert property (@(posedge clk) disable iff (rst)
        s_q.activeChans inside {3'h1, 3'h2, 3'h3, 3'h4})
        else $error("illegal channel count");

    // inactive channels never report a cycle end
    chk_inactive_no_end: assert property (@(posedge clk) disable iff (rst)
        (cycleEnd & ~chanActive) == '0)
        else $error("cycle end on inactive channel");

    // cover points for the main scenarios
    cov_droop: cover property (@(posedge clk) disable iff (rst) $rose(fast_droop_all_on));
    cov_three: cover property (@(posedge clk) disable iff (rst) s_q.activeChans == 3'h3 && corePwm[2]);
    cov_pulse: cover property (@(posedge clk) disable iff (rst) cycleEnd[0]);
    cov_two: cover property (@(posedge clk) disable iff (rst) s_q.activeChans == 3'h2 && corePwm[1]);
    cov_single: cover property (@(posedge clk) disable iff (rst) s_q.activeChans == 3'h1 && cycleEnd[0]);
endmodule

// ---- mps_gate_driver_model.sv ----
// gate driver model: pwm level to high-side and low-side switch commands
module mps_gate_driver_model
    import mps_pkg::*;
(
    input wire logic [MAX_CHANNELS-1:0] pwm,
    output logic [MAX_CHANNELS-1:0] hsOn,
    output logic [MAX_CHANNELS-1:0] lsOn
);
    timeunit 1ns;
    timeprecision 1ns;
    // high level turns the high side on, low level the low side
    assign hsOn = pwm;
    assign lsOn = ~pwm;
endmodule

// ---- tb_multiphase_pwm_sequencer.sv ----
// testbench for the multiphase pwm sequencer
module tb_multiphase_pwm_sequencer;
    import mps_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int P = 12;
    logic clk = 0, rst = 1, c2 = 0, c3 = 0, c4 = 0, nbIn = 0, armed = 0;
    mps_analog_t cmp = '0;
    logic [3:0] pwm, act, cEnd, hsOn, lsOn, pv, seen;
    logic allOn, nbOut;
    int fails = 0, total_checks = 0, cyc = 0, r0, nbHigh, cnt0;
    int ra [4];
    // strap rows: pins {4,3,2}, expected mask, channel count
    logic [2:0] rowStrap [4] = '{3'h4, 3'h6, 3'h7, 3'h0};
    logic [3:0] rowMask [4] = '{4'h7, 4'h3, 4'h1, 4'hf};
    int rowN [4] = '{3, 2, 1, 4};
    always #50 clk = ~clk;
    mps_sequencer #(.PERIOD_CYCLES(16'h000c)) mps_sequencer_inst (.clk(clk), .rst(rst),
        .chan2_detect_pin(c2), .chan3_detect_pin(c3), .chan4_detect_pin(c4),
        .coreCmp(cmp), .nbCrossAbove(nbIn), .corePwm(pwm), .chanActive(act),
        .cycleEnd(cEnd), .fast_droop_all_on(allOn), .nbPwm(nbOut));
    mps_gate_driver_model mps_gate_driver_model_inst (.pwm(pwm), .hsOn(hsOn), .lsOn(lsOn));
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // rise tracking on the settled falling edge
    always @(negedge clk) begin
        cyc <= cyc + 1;
        pv <= pwm;
        if (armed) begin
            nbHigh <= nbHigh + int'(nbOut);
            for (int i = 0; i < 4; i++) begin
                if (pwm[i] && !pv[i]) begin
                    seen[i] <= 1'b1;
                    if (i == 0) cnt0 <= cnt0 + 1;
                    if (i == 0 && r0 < 0) r0 <= cyc;
                    if (i > 0 && r0 >= 0 && ra[i] < 0) ra[i] <= cyc - r0;
                end
            end
        end
    end
    // watchdog against a hang
    initial begin
        #200us;
        fails++;
        close_out();
    end
    initial begin
        for (int k = 0; k < 4; k++) begin
            {c4, c3, c2} <= rowStrap[k];
            rst <= 1'b1;
            cycles(5);
            rst <= 1'b0;
            cycles(8);
            chk(act, rowMask[k]);
            {c4, c3, c2} <= ~rowStrap[k];
            r0 = -1;
            nbHigh = 0;
            cnt0 = 0;
            seen = 4'h0;
            ra = '{-1, -1, -1, -1};
            // comparator toggles every cycle; one warm-up interval drains rises left from reset
            for (int t = 0; t < 4 * P; t++) begin
                @(posedge clk);
                if (t == P) armed = 1'b1;
                cmp.crossAbove <= {4{t[0]}};
                nbIn <= t[0];
            end
            cycles(2);
            armed = 1'b0;
            chk(act, rowMask[k]);
            chk(seen, rowMask[k]);
            chk(4'(cnt0 >= 3 && cnt0 <= 4), 4'h1);
            chk(4'(nbHigh > 0), 4'h1);
            for (int i = 1; i < rowN[k]; i++) begin
                chk(4'(ra[i] >= P * i / rowN[k] - 1 && ra[i] <= P * i / rowN[k] + 1), 4'h1);
            end
        end
        // single pulse walk on channel one
        @(posedge clk) cmp.crossAbove <= 4'h0;
        cycles(P + 2);
        chk(pwm, 4'h0);
        @(posedge clk) cmp.crossAbove <= 4'h1;
        cycles(2 * P);
        chk(pwm, 4'h1);
        @(posedge clk) cmp.crossAbove <= 4'h0;
        cycles(1);
        chk(pwm, 4'h0);
        chk(cEnd, 4'h1);
        cycles(1);
        chk(cEnd, 4'h0);
        // droop trip forces every active high side on
        @(posedge clk) cmp.droopTrip <= 1'b1;
        cycles(3);
        chk(pwm, 4'hf);
        chk({3'h0, allOn}, 4'h1);
        chk(hsOn & ~lsOn, 4'hf);
        @(posedge clk) cmp.droopTrip <= 1'b0;
        cycles(4);
        chk(pwm, 4'h0);
        close_out();
    end
endmodule
